// >>> bench/nibble_logic_skip_unit_bench.sv
// nibble_logic_skip_unit_bench: random ops against a reference model.
// assumes nlsu_core holds its memory inside and memory powers up unknown.
module nibble_logic_skip_unit_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i, rstn_i, op_valid, cy, sk, skg, ec, es;
   logic [3:0] op, imm, acc, ea;
   logic [5:0] ptr;
   logic [3:0] mem [64];
   logic [6:0] expq [$];
   int errors, n_checks, cyc;
   initial begin clock_i = 0; forever #5 clock_i = ~clock_i; end
   nlsu_seq_model nlsu_seq_model_inst (.clock_i, .op_valid_o(op_valid), .op_o(op), .imm_o(imm),
      .ptr_o(ptr));
   nlsu_core nlsu_core_inst (.clock_i, .rstn_i, .op_valid_i(op_valid), .op_i(op), .imm_i(imm),
      .data_pointer_i(ptr), .acc_o(acc), .carry_flag_o(cy), .skip_o(sk), .skipping_o(skg));
   // -----------------
   // checks and model
   // -----------------
   task chk(string nm, logic [6:0] e, logic [6:0] s);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task wrap_up();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task run(input logic [3:0] o, input logic [3:0] m, input logic [5:0] p);
      logic [3:0] d;
      d = mem[p];
      if (es) es = 0;
      else case (o)
         1: ea &= d;
         2: ea |= d;
         3: ec = 1;
         4: ec = 0;
         5: es = !ec;
         6: ea = ~ea;
         7: {ea, ec} = {ec, ea};
         8: mem[p][m[1:0]] = 1;
         9: mem[p][m[1:0]] = 0;
         10: es = !d[m[1:0]];
         11: es = (ea == d);
         12: es = (ea == m);
         default: ;
      endcase
      expq.push_back({ea, ec, es, es});
      nlsu_seq_model_inst.issue(o, m, p);
   endtask
   // result watcher takes the oldest note once each valid op, skipped or not, has landed
   always @(posedge clock_i) if (rstn_i === 1'b1 && op_valid === 1'b1) begin
      @(negedge clock_i);
      chk("outputs", expq.pop_front(), {acc, cy, sk, skg});
   end
   always @(posedge clock_i) begin
      cyc++;
      if (cyc > 3000) begin
         errors++;
         wrap_up();
      end
   end
   initial begin
      rstn_i = 0; ea = 0; ec = 0; es = 0;
      void'($urandom(32'hE8CC));
      repeat (10) @(negedge clock_i);
      rstn_i = 1;
      chk("reset", 7'h00, {acc, cy, sk, skg});
      // known contents for addresses 0 to 3, since memory is not reset
      for (int i = 0; i < 16; i++) run(4'h8 + 4'($urandom % 2), 4'(i), 6'(i / 4));
      repeat (400) run(4'($urandom), 4'($urandom), 6'($urandom % 4));
      nlsu_seq_model_inst.idle();
      repeat (2) @(negedge clock_i);
      // every noted result must have been taken off by the watcher
      chk("left", 7'h00, 7'(expq.size()));
      wrap_up();
   end
endmodule
bind nlsu_core nlsu_core_monitor nlsu_core_monitor_inst (.clock_i, .rstn_i, .op_valid_i, .op_i,
   .imm_i, .acc_o, .carry_flag_o, .skip_o, .skipping_o);

// >>> bench/nlsu_core_monitor.sv
// nlsu_core_monitor: port-level checks on the nibble logic and skip unit.
// assumes it is bound to nlsu_core and sees only its ports.
module nlsu_core_monitor (
   input wire logic       clock_i,
   input wire logic       rstn_i,
   input wire logic       op_valid_i,
   input wire logic [3:0] op_i,
   input wire logic [3:0] imm_i,
   input wire logic [3:0] acc_o,
   input wire logic       carry_flag_o,
   input wire logic       skip_o,
   input wire logic       skipping_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // -----------------
   // properties
   // -----------------
   // an op that is not being suppressed by a pending skip
   logic go;
   assign go = op_valid_i && !skip_o;
   property p_setc; go && op_i == 4'h3 |=> carry_flag_o && $stable(acc_o); endproperty
   a_setc: assert property (p_setc) else $error("set carry wrong");
   property p_clrc; go && op_i == 4'h4 |=> !carry_flag_o && $stable(acc_o); endproperty
   a_clrc: assert property (p_clrc) else $error("clear carry wrong");
   property p_tstc; go && op_i == 4'h5 |=> skip_o == !$past(carry_flag_o); endproperty
   a_tstc: assert property (p_tstc) else $error("carry test wrong");
   property p_cmpl; go && op_i == 4'h6 |=> acc_o == ~$past(acc_o) && $stable(carry_flag_o);
   endproperty
   a_cmpl: assert property (p_cmpl) else $error("complement wrong");
   property p_ror;
      go && op_i == 4'h7 |=> {acc_o, carry_flag_o} == {$past(carry_flag_o), $past(acc_o)};
   endproperty
   a_ror: assert property (p_ror) else $error("rotate wrong");
   property p_eqi;
      go && op_i == 4'hC |=> skip_o == ($past(acc_o) == $past(imm_i)) && $stable(acc_o);
   endproperty
   a_eqi: assert property (p_eqi) else $error("immediate compare wrong");
   property p_keep; go && op_i inside {4'h1, 4'h2} |=> $stable(carry_flag_o) && !skip_o;
   endproperty
   a_keep: assert property (p_keep) else $error("logic op touched carry");
   property p_sup; op_valid_i && skip_o |=> !skip_o && $stable({acc_o, carry_flag_o}); endproperty
   a_sup: assert property (p_sup) else $error("skipped op took effect");
   property p_skg; skipping_o == skip_o; endproperty
   a_skg: assert property (p_skg) else $error("skip outputs disagree");
   c_skip: cover property (go && op_i == 4'h5 ##1 skip_o);
   c_sup: cover property (op_valid_i && skip_o && skipping_o);
   c_ror: cover property (go && op_i == 4'h7 && carry_flag_o);
endmodule

// >>> bench/nlsu_seq_model.sv
// nlsu_seq_model: stand-in for the decoder and sequencer feeding operations.
// assumes the caller drives it between falling edges of clock_i.
module nlsu_seq_model (
   input  wire logic       clock_i,
   output logic            op_valid_o,
   output logic      [3:0] op_o,
   output logic      [3:0] imm_o,
   output logic      [5:0] ptr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // -----------------
   // issue one op
   // -----------------
   initial begin
      op_valid_o = 1'h0;
      op_o       = 4'h0;
      imm_o      = 4'h0;
      ptr_o      = 6'h00;
   end
   // pointer goes out a cycle early since the memory read is registered;
   // the idle cycle also lets a bit write settle before the next read
   task automatic issue(input logic [3:0] o, input logic [3:0] m, input logic [5:0] p);
      @(negedge clock_i);
      op_valid_o = 1'h0;
      ptr_o      = p;
      @(negedge clock_i);
      op_valid_o = 1'h1;
      op_o       = o;
      imm_o      = m;
   endtask
   // drop the strobe after the last op so it is taken only once
   task automatic idle();
      @(negedge clock_i);
      op_valid_o = 1'h0;
   endtask
endmodule

// >>> hw/nlsu_core.sv
// nlsu_core: accumulator, carry flag and skip logic for nibble logic and bit instructions.
// assumes the sequencer gives op_valid_i for one cycle per instruction, holds the
// data pointer one cycle ahead (the memory read is registered) and honours skip_o.
//
// How it works
// RULE_01: and memory into accumulator, carry kept
// RULE_02: or memory into accumulator, carry kept
// RULE_03: set carry, nothing else changes
// RULE_04: clear carry, nothing else changes
// RULE_05: skip next when carry is zero
// RULE_06: invert every accumulator bit, carry kept
// RULE_07: rotate carry and accumulator right by one
// RULE_08: set selected memory bit, others kept
// RULE_09: clear selected memory bit, others kept
// RULE_10: skip next when selected memory bit zero
// RULE_11: skip next when accumulator equals memory
// RULE_12: skip next when accumulator equals immediate
// RULE_13: skipped instruction changes no state
module nlsu_core #(
   parameter int PTR_W = nlsu_pkg::PTR_W
) (
   input  wire logic                   clock_i,
   input  wire logic                   rstn_i,
   input  wire logic                   op_valid_i,
   input  wire logic [3:0]             op_i,
   input  wire logic [nlsu_pkg::MSB:0] imm_i,
   input  wire logic [PTR_W-1:0]       data_pointer_i,
   output logic      [nlsu_pkg::MSB:0] acc_o,
   output logic                        carry_flag_o,
   output logic                        skip_o,
   output logic                        skipping_o
);
   // ----------------------------------------
   // local constants
   // ----------------------------------------
   localparam logic SKIP_RST = 1'h0;  // no skip pending out of reset
   localparam int   ACC_LSB  = 0;     // accumulator bit that rotates out into carry

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [nlsu_pkg::MSB:0]      acc_reg;
   logic [nlsu_pkg::MSB:0]      acc_next;
   logic                        carry_reg;
   logic                        carry_next;
   logic                        skip_reg;
   logic                        skip_next;

   // ----------------------------------------
   // decode and operands
   // ----------------------------------------
   nlsu_pkg::nlsu_op_t          op;
   logic                        take;
   logic [nlsu_pkg::BSEL_W-1:0] bit_sel;
   logic [nlsu_pkg::MSB:0]      sel_mask;
   logic                        sel_bit_clear;
   logic                        acc_eq_mem;
   logic                        acc_eq_imm;
   logic [nlsu_pkg::MSB:0]      pointed_memory_nibble;
   logic                        mem_we;
   logic [nlsu_pkg::MSB:0]      mem_wdata;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // one-hot mask of the bit picked by the low immediate field
   function automatic logic [nlsu_pkg::MSB:0] bit_mask(
      input logic [nlsu_pkg::BSEL_W-1:0] sel
   );
      logic [nlsu_pkg::MSB:0] m;
      m      = '0;
      m[sel] = 1'h1;
      return m;
   endfunction

   // nibble compare shared by the memory and the immediate skip tests
   function automatic logic nib_equal(
      input logic [nlsu_pkg::MSB:0] a,
      input logic [nlsu_pkg::MSB:0] b
   );
      return (a == b);
   endfunction

   // read-modify-write of one memory bit; the other three bits pass through
   function automatic logic [nlsu_pkg::MSB:0] bit_write(
      input logic [nlsu_pkg::MSB:0] nib,
      input logic [nlsu_pkg::MSB:0] mask,
      input logic                   value
   );
      logic [nlsu_pkg::MSB:0] r;
      r = value ? (nib | mask) : (nib & ~mask);
      return r;
   endfunction

   // codes outside the table fall through to the nop branches below;
   // reset blocks a take too, so a bit op held during reset cannot reach memory
   assign op            = nlsu_pkg::nlsu_op_t'(op_i);
   assign take          = op_valid_i && rstn_i && !skip_reg;  // [RULE_13]
   assign bit_sel       = imm_i[nlsu_pkg::BSEL_W-1:0];
   assign sel_mask      = bit_mask(bit_sel);
   assign sel_bit_clear = ~|(pointed_memory_nibble & sel_mask);
   assign acc_eq_mem    = nib_equal(acc_reg, pointed_memory_nibble);
   assign acc_eq_imm    = nib_equal(acc_reg, imm_i);

   // ----------------------------------------
   // data memory
   // ----------------------------------------
   // read and write share the pointer; the read for the op cycle is launched a
   // cycle earlier, so the pointer must stand from the cycle before the op
   nlsu_mem #(
      .DEPTH_LOG2 (PTR_W)
   ) nlsu_mem_inst (
      .clock_i (clock_i),
      .raddr_i (data_pointer_i),
      .we_i    (mem_we),
      .waddr_i (data_pointer_i),
      .wdata_i (mem_wdata),
      .rdata_o (pointed_memory_nibble)
   );

   // ----------------------------------------
   // accumulator and carry
   // ----------------------------------------
   // only a taken op moves them; tests and bit ops leave both alone
   always_comb begin
      acc_next   = acc_reg;
      carry_next = carry_reg;
      if (take) begin
         unique case (op)
            nlsu_pkg::NLSU_OP_AND: begin
               acc_next = acc_reg & pointed_memory_nibble;                  // [RULE_01]
            end
            nlsu_pkg::NLSU_OP_OR: begin
               acc_next = acc_reg | pointed_memory_nibble;                  // [RULE_02]
            end
            nlsu_pkg::NLSU_OP_SETC: begin
               carry_next = 1'h1;                                           // [RULE_03]
            end
            nlsu_pkg::NLSU_OP_CLRC: begin
               carry_next = 1'h0;                                           // [RULE_04]
            end
            nlsu_pkg::NLSU_OP_CMPL: begin
               acc_next = ~acc_reg;                                         // [RULE_06]
            end
            nlsu_pkg::NLSU_OP_ROR: begin
               // five-bit chain: carry drops in on top, the low bit falls out
               acc_next   = {carry_reg, acc_reg[nlsu_pkg::MSB:ACC_LSB+1]};  // [RULE_07]
               carry_next = acc_reg[ACC_LSB];                               // [RULE_07]
            end
            default: begin
               // nop, unused codes, skip tests and bit ops
            end
         endcase
      end
   end

   // synchronous reset to the package values
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         acc_reg   <= nlsu_pkg::ACC_RST;
         carry_reg <= nlsu_pkg::CARRY_RST;
      end else begin
         acc_reg   <= acc_next;
         carry_reg <= carry_next;
      end
   end

   // ----------------------------------------
   // skip request
   // ----------------------------------------
   // any valid op clears a pending skip, swallowed or not; only a taken test
   // may raise a new one, so a skipped test can never chain a second skip
   always_comb begin
      skip_next = skip_reg;
      if (op_valid_i) begin
         skip_next = 1'h0;
      end
      if (take) begin
         unique case (op)
            nlsu_pkg::NLSU_OP_TSTC: begin
               skip_next = ~carry_reg;                                      // [RULE_05]
            end
            nlsu_pkg::NLSU_OP_BTST: begin
               skip_next = sel_bit_clear;                                   // [RULE_10]
            end
            nlsu_pkg::NLSU_OP_EQM: begin
               skip_next = acc_eq_mem;                                      // [RULE_11]
            end
            nlsu_pkg::NLSU_OP_EQI: begin
               skip_next = acc_eq_imm;                                      // [RULE_12]
            end
            default: begin
               // every other code leaves the skip cleared
            end
         endcase
      end
   end

   // skip flag; reset drops any pending skip
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         skip_reg <= SKIP_RST;
      end else begin
         skip_reg <= skip_next;
      end
   end

   // ----------------------------------------
   // memory bit writes
   // ----------------------------------------
   // the write lands at the op edge; the registered read shows it a cycle
   // later, so the sequencer leaves a gap before the same nibble is read back
   always_comb begin
      mem_we    = 1'h0;
      mem_wdata = pointed_memory_nibble;
      if (take) begin
         unique case (op)
            nlsu_pkg::NLSU_OP_BSET: begin
               mem_we    = 1'h1;
               mem_wdata = bit_write(pointed_memory_nibble, sel_mask, 1'h1); // [RULE_08]
            end
            nlsu_pkg::NLSU_OP_BCLR: begin
               mem_we    = 1'h1;
               mem_wdata = bit_write(pointed_memory_nibble, sel_mask, 1'h0); // [RULE_09]
            end
            default: begin
               // no other op writes memory
            end
         endcase
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // every output is a flop; skipping_o mirrors skip_o for the fetch stage
   assign acc_o        = acc_reg;
   assign carry_flag_o = carry_reg;
   assign skip_o       = skip_reg;
   assign skipping_o   = skip_reg;
endmodule

// >>> hw/nlsu_mem.sv
// nlsu_mem: data memory of nibbles, one write port and one registered read port.
// assumes address and write data are stable in the cycle of the write strobe.
module nlsu_mem #(
   parameter int DEPTH_LOG2 = nlsu_pkg::PTR_W
) (
   input  wire logic                      clock_i,
   input  wire logic [DEPTH_LOG2-1:0]     raddr_i,
   input  wire logic                      we_i,
   input  wire logic [DEPTH_LOG2-1:0]     waddr_i,
   input  wire logic [nlsu_pkg::MSB:0]    wdata_i,
   output logic      [nlsu_pkg::MSB:0]    rdata_o
);
   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [nlsu_pkg::MSB:0] mem_reg [2**DEPTH_LOG2];

   // write and registered read; contents are undefined until software writes them
   always_ff @(posedge clock_i) begin
      if (we_i) begin
         mem_reg[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_reg[raddr_i];
   end
endmodule

// >>> hw/nlsu_pkg.sv
// nlsu_pkg: operation codes, widths and field positions for the nibble logic and skip unit.
// assumes the decoder presents one operation code per instruction cycle.
package nlsu_pkg;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int NIB_W  = 4;
   localparam int BSEL_W = 2;
   localparam int PTR_W  = 6;
   localparam int MSB    = NIB_W - 1;

   // ----------------------------------------
   // operation codes
   // ----------------------------------------
   typedef enum logic [3:0] {
      NLSU_OP_NOP  = 4'h0,
      NLSU_OP_AND  = 4'h1,
      NLSU_OP_OR   = 4'h2,
      NLSU_OP_SETC = 4'h3,
      NLSU_OP_CLRC = 4'h4,
      NLSU_OP_TSTC = 4'h5,
      NLSU_OP_CMPL = 4'h6,
      NLSU_OP_ROR  = 4'h7,
      NLSU_OP_BSET = 4'h8,
      NLSU_OP_BCLR = 4'h9,
      NLSU_OP_BTST = 4'hA,
      NLSU_OP_EQM  = 4'hB,
      NLSU_OP_EQI  = 4'hC
   } nlsu_op_t;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [NIB_W-1:0] ACC_RST   = 4'h0;
   localparam logic             CARRY_RST = 1'b0;
endpackage
